// File: hdl/ebsme_pkg.sv
package ebsme_pkg;

    // ==========================================================
    // Clock and timing
    // ==========================================================
    localparam int unsigned CORE_CLK_MHZ     = 100;
    localparam int unsigned OSC_PER_MC_X1    = 12;
    localparam int unsigned OSC_PER_MC_X2    = 6;
    localparam int unsigned RST_HOLD_MC      = 2;
    localparam int unsigned HOST_HOLD_MC     = 20;
    localparam int unsigned PHASE_W          = 4;
    localparam int unsigned HOLD_W           = 5;

    localparam logic [PHASE_W-1:0] PH_ZERO   = 4'h0;
    localparam logic [PHASE_W-1:0] PH_ALE1   = 4'h0;
    localparam logic [PHASE_W-1:0] PH_ALE2_X1 = 4'h6;
    localparam logic [PHASE_W-1:0] PH_ALE2_X2 = 4'h3;
    localparam logic [PHASE_W-1:0] PH_RD_X1  = 4'h7;
    localparam logic [PHASE_W-1:0] PH_RD_X2  = 4'h4;
    localparam logic [PHASE_W-1:0] PH_PS1_X1 = 4'h2;
    localparam logic [PHASE_W-1:0] PH_PS2_X1 = 4'h8;
    localparam logic [PHASE_W-1:0] PH_PS1_X2 = 4'h1;
    localparam logic [PHASE_W-1:0] PH_PS2_X2 = 4'h4;
    localparam logic [PHASE_W-1:0] PH_LEN    = 4'h3;
    // Shorter pulses in double speed, or the two pulses of a cycle merge
    localparam logic [PHASE_W-1:0] PH_LEN_X2 = 4'h2;

    localparam logic [1:0] LOCK_LEVEL_MAX    = 2'h3;

    // ==========================================================
    // Types
    // ==========================================================
    typedef enum logic [1:0] {
        EBSME_ST_RESET,
        EBSME_ST_SAMPLE,
        EBSME_ST_NORMAL,
        EBSME_ST_HOST
    } ebsme_mode_e;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic        wide;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } ebsme_xdata_s;

    typedef struct packed {
        logic       ps_rd_n;
        logic       ale;
        logic       rd_n;
        logic       wr_n;
        logic [7:0] addr_hi;
        logic       addr_hi_oe_n;
    } ebsme_pins_s;

endpackage

// File: hdl/ebsme_osc_div.sv
`timescale 1ns/100ps
module ebsme_osc_div
    import ebsme_pkg::*;
(
    // Clock and reset
    input  wire logic               i_core_clk,
    input  wire logic               i_rst_b,
    // Control
    input  wire logic               i_osc_tick,
    input  wire logic               i_double_speed,
    // Phase
    output logic [ebsme_pkg::PHASE_W-1:0] o_phase,
    output logic                    o_mc_start
);
    import ebsme_pkg::*;

    logic [PHASE_W-1:0] last;

    // Twelve oscillator periods per cycle, six in double speed
    assign last = i_double_speed ? PHASE_W'(OSC_PER_MC_X2 - 1) : PHASE_W'(OSC_PER_MC_X1 - 1);

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_phase <= PH_ZERO;
        end else if (i_osc_tick) begin
            o_phase <= (o_phase >= last) ? PH_ZERO : o_phase + 1'b1;
        end
    end

    assign o_mc_start = i_osc_tick && (o_phase >= last);
endmodule

// File: hdl/ebsme_top.sv
`timescale 1ns/100ps
// How it works
// - Reset input high for two sampled machine cycles resets the device.
// - Strobe pin falling after reset held more than twenty machine cycles enters host programming mode.
// - Program store strobe stays high while running from internal memory.
// - External fetch pulses the strobe twice per cycle, once on data cycles.
// - Lock level 3 ignores access select and forces internal execution.
// - Latch strobe pulses so outside logic catches the low address byte.
// - Default mode latch strobe runs at one sixth of crystal rate.
// - One latch strobe pulse dropped in each external data cycle.
// - Latch strobe off bit set to one stops latch strobe pulses.
// - Active-low data read and write strobes share port pins.
// - During flash programming the latch pin is the programming pulse input.
// - Double speed mode runs the latch strobe at one third crystal rate.
// - High address byte driven for external fetches and wide data cycles.
module ebsme_top
    import ebsme_pkg::*;
(
    // Clock and reset
    input  wire logic               i_core_clk,
    input  wire logic               i_rst_b,
    // Oscillator timing
    input  wire logic               i_osc_tick,
    input  wire logic               i_double_speed,
    // Configuration
    input  wire logic               i_latch_strobe_off_bit,
    input  wire logic [1:0]         i_lock_level,
    input  wire logic [15:0]        i_fetch_addr,
    input  wire ebsme_pkg::ebsme_xdata_s i_xdata,
    // Pins in
    input  wire logic               i_reset_pin,
    input  wire logic               i_external_access_select,
    input  wire logic               i_ps_rd_pin,
    input  wire logic               i_ale_pin,
    // Pins out
    output logic                    o_program_store_read_strobe,
    output logic                    o_program_store_read_strobe_oe_n,
    output logic                    o_ale,
    output logic                    o_ale_oe_n,
    output logic                    o_rd_n,
    output logic                    o_wr_n,
    output logic [7:0]              o_addr_hi,
    output logic                    o_addr_hi_oe_n,
    // Status
    output logic                    o_core_reset,
    output logic                    o_host_mode,
    output logic                    o_external_exec,
    output logic                    o_mc_start,
    output logic                    o_programming_pulse_input
);
    import ebsme_pkg::*;

    // ==========================================================
    // Reset release and cycle timing
    // ==========================================================
    logic               rst_meta;
    logic               rst_sync_b;
    logic [PHASE_W-1:0] phase;
    logic               mc_start;
    logic               dbl;

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_meta   <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_meta   <= 1'b1;
            rst_sync_b <= rst_meta;
        end
    end

    assign dbl = i_double_speed;

    ebsme_osc_div u_div (
        .i_core_clk     (i_core_clk),
        .i_rst_b        (rst_sync_b),
        .i_osc_tick     (i_osc_tick),
        .i_double_speed (dbl),
        .o_phase        (phase),
        .o_mc_start     (mc_start)
    );

    // ==========================================================
    // Reset detection and mode entry
    // ==========================================================
    logic [HOLD_W-1:0] rst_hi_mc;
    logic              ps_prev;
    logic              ps_fell;
    ebsme_mode_e       mode;

    // Count machine cycle starts seen with reset pin held high
    always_ff @(posedge i_core_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            rst_hi_mc <= '0;
        end else if (!i_reset_pin) begin
            rst_hi_mc <= '0;
        end else if (mc_start && rst_hi_mc != '1) begin
            rst_hi_mc <= rst_hi_mc + 1'b1;
        end
    end

    always_ff @(posedge i_core_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            ps_prev <= 1'b1;
        end else begin
            ps_prev <= i_ps_rd_pin;
        end
    end

    assign ps_fell = ps_prev && !i_ps_rd_pin;

    // Host entry needs the programmer to keep reset high past the hold
    always_ff @(posedge i_core_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            mode <= EBSME_ST_RESET;
        end else begin
            unique case (mode)
                EBSME_ST_RESET: begin
                    if (!i_reset_pin) begin
                        mode <= EBSME_ST_NORMAL;
                    end else if (rst_hi_mc >= HOLD_W'(RST_HOLD_MC)) begin
                        mode <= EBSME_ST_SAMPLE;
                    end
                end
                EBSME_ST_SAMPLE: begin
                    if (!i_reset_pin) begin
                        mode <= EBSME_ST_NORMAL;
                    end else if (ps_fell && rst_hi_mc > HOLD_W'(HOST_HOLD_MC)) begin
                        mode <= EBSME_ST_HOST;
                    end
                end
                EBSME_ST_NORMAL: begin
                    if (rst_hi_mc >= HOLD_W'(RST_HOLD_MC)) begin
                        mode <= EBSME_ST_SAMPLE;
                    end
                end
                EBSME_ST_HOST: begin
                    if (!i_reset_pin) begin
                        mode <= EBSME_ST_NORMAL;
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // Execution source
    // ==========================================================
    logic ext_exec;
    logic run;

    assign run = (mode == EBSME_ST_NORMAL);
    // Top lock level overrides the select pin
    assign ext_exec = run && !i_external_access_select
                      && (i_lock_level != LOCK_LEVEL_MAX);

    // ==========================================================
    // Strobe generation
    // ==========================================================
    logic               data_cyc;
    logic               data_wr;
    logic               data_wide;
    logic [15:0]        data_addr;
    logic [PHASE_W-1:0] ale2_ph;
    logic [PHASE_W-1:0] rd_ph;
    logic [PHASE_W-1:0] ps1_ph;
    logic [PHASE_W-1:0] ps2_ph;
    logic [PHASE_W-1:0] pulse_len;
    logic               next_ale;
    logic               next_ps;
    logic               next_rd_n;
    logic               next_wr_n;

    assign ale2_ph = dbl ? PH_ALE2_X2 : PH_ALE2_X1;
    assign rd_ph   = dbl ? PH_RD_X2   : PH_RD_X1;
    assign ps1_ph  = dbl ? PH_PS1_X2  : PH_PS1_X1;
    assign ps2_ph  = dbl ? PH_PS2_X2  : PH_PS2_X1;
    assign pulse_len = dbl ? PH_LEN_X2 : PH_LEN;

    // Data request is held for the whole machine cycle it starts
    always_ff @(posedge i_core_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            data_cyc  <= 1'b0;
            data_wr   <= 1'b0;
            data_wide <= 1'b0;
            data_addr <= '0;
        end else if (mc_start) begin
            data_cyc  <= i_xdata.valid && run;
            data_wr   <= i_xdata.write;
            data_wide <= i_xdata.wide;
            data_addr <= i_xdata.addr;
        end
    end

    always_comb begin
        next_ale = 1'b0;
        if (run && !i_latch_strobe_off_bit) begin
            if (phase < pulse_len) begin
                next_ale = 1'b1;
            end else if (phase >= ale2_ph && phase < ale2_ph + pulse_len && !data_cyc) begin
                next_ale = 1'b1;
            end
        end
        next_ps = 1'b1;
        if (ext_exec) begin
            if (phase >= ps1_ph && phase < ps1_ph + pulse_len) begin
                next_ps = 1'b0;
            end else if (!data_cyc && phase >= ps2_ph && phase < ps2_ph + pulse_len) begin
                next_ps = 1'b0;
            end
        end
        next_rd_n = 1'b1;
        next_wr_n = 1'b1;
        if (data_cyc && phase >= rd_ph) begin
            next_rd_n = data_wr;
            next_wr_n = !data_wr;
        end
    end

    // Pins registered so every output leaves a flip-flop
    always_ff @(posedge i_core_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            o_ale                            <= 1'b0;
            o_ale_oe_n                       <= 1'b1;
            o_program_store_read_strobe      <= 1'b1;
            o_program_store_read_strobe_oe_n <= 1'b1;
            o_rd_n                           <= 1'b1;
            o_wr_n                           <= 1'b1;
        end else begin
            o_ale                            <= next_ale;
            o_ale_oe_n                       <= (mode == EBSME_ST_HOST) || !run;
            o_program_store_read_strobe      <= next_ps;
            o_program_store_read_strobe_oe_n <= !run;
            o_rd_n                           <= next_rd_n;
            o_wr_n                           <= next_wr_n;
        end
    end

    // ==========================================================
    // High address byte
    // ==========================================================
    always_ff @(posedge i_core_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            o_addr_hi      <= 8'h00;
            o_addr_hi_oe_n <= 1'b1;
        end else if (data_cyc && data_wide && phase >= ale2_ph) begin
            o_addr_hi      <= data_addr[15:8];
            o_addr_hi_oe_n <= 1'b0;
        end else if (ext_exec) begin
            o_addr_hi      <= i_fetch_addr[15:8];
            o_addr_hi_oe_n <= 1'b0;
        end else begin
            o_addr_hi_oe_n <= 1'b1;
        end
    end

    // ==========================================================
    // Status
    // ==========================================================
    always_ff @(posedge i_core_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            o_core_reset              <= 1'b1;
            o_host_mode               <= 1'b0;
            o_external_exec           <= 1'b0;
            o_mc_start                <= 1'b0;
            o_programming_pulse_input <= 1'b1;
        end else begin
            o_core_reset              <= !run && (mode != EBSME_ST_HOST);
            o_host_mode               <= (mode == EBSME_ST_HOST);
            o_external_exec           <= ext_exec;
            o_mc_start                <= mc_start;
            o_programming_pulse_input <= (mode == EBSME_ST_HOST) ? i_ale_pin : 1'b1;
        end
    end
endmodule

// File: tb/ebsme_top_assertions.sv
`timescale 1ns/100ps
module ebsme_top_assertions (
    // Clock and reset
    input wire logic       i_core_clk,
    input wire logic       i_rst_b,
    // Inputs
    input wire logic       i_latch_strobe_off_bit,
    input wire logic [1:0] i_lock_level,
    input wire logic       i_reset_pin,
    input wire logic       i_ale_pin,
    // Outputs
    input wire logic       o_program_store_read_strobe,
    input wire logic       o_ale,
    input wire logic       o_ale_oe_n,
    input wire logic       o_rd_n,
    input wire logic       o_wr_n,
    input wire logic       o_core_reset,
    input wire logic       o_host_mode,
    input wire logic       o_external_exec,
    input wire logic       o_programming_pulse_input
);
    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_b);

    // Eight cycles of margin let a strobe in flight finish
    a_int_strobe_idle: assert property (
        !o_external_exec [*8] |-> o_program_store_read_strobe)
        else $error("code strobe active in internal run");
    a_lock_internal: assert property (
        $rose(o_external_exec) |-> i_lock_level != 2'h3)
        else $error("external run under top lock");
    a_ale_disabled: assert property (
        i_latch_strobe_off_bit [*8] |-> !o_ale)
        else $error("latch pulse while disabled");
    a_data_no_ale: assert property (
        $fell(o_rd_n) || $fell(o_wr_n) |-> !o_ale)
        else $error("latch pulse not dropped in data cycle");
    a_data_one_strobe: assert property (
        !o_rd_n || !o_wr_n |-> o_program_store_read_strobe)
        else $error("code strobe during data strobe");
    a_rd_wr_excl: assert property (!o_rd_n |-> o_wr_n)
        else $error("read and write strobes together");
    // Core reset flag clears on the same edge that raises host mode
    a_host_in_reset: assert property (
        $rose(o_host_mode) |-> i_reset_pin && $past(o_core_reset))
        else $error("host mode without held reset");
    a_programming_pulse_input_pulse_copy: assert property (
        o_host_mode [*2] |-> o_programming_pulse_input == $past(i_ale_pin) && o_ale_oe_n)
        else $error("latch pin not taken as input");
    a_reset_quiet: assert property (
        o_core_reset [*3] |-> o_program_store_read_strobe && o_rd_n && o_wr_n && !o_ale)
        else $error("strobes active while held in reset");

    c_read: cover property ($fell(o_rd_n));
    c_write: cover property ($fell(o_wr_n));
    c_host: cover property ($rose(o_host_mode));
endmodule

bind ebsme_top ebsme_top_assertions u_chk (
    .i_core_clk, .i_rst_b, .i_latch_strobe_off_bit, .i_lock_level, .i_reset_pin,
    .i_ale_pin, .o_program_store_read_strobe, .o_ale, .o_ale_oe_n, .o_rd_n, .o_wr_n,
    .o_core_reset, .o_host_mode, .o_external_exec, .o_programming_pulse_input
);

// File: tb/ebsme_mem_model.sv
`timescale 1ns/100ps
module ebsme_mem_model (
    // Clock
    input  wire logic       i_core_clk,
    // Device side
    input  wire logic       i_ps_n,
    input  wire logic       i_ps_oe_n,
    input  wire logic       i_ale,
    input  wire logic       i_ale_oe_n,
    input  wire logic       i_rd_n,
    input  wire logic       i_wr_n,
    input  wire logic [7:0] i_addr_hi,
    // Programmer side
    input  wire logic       i_programming_pulse_input_ps,
    input  wire logic       i_programming_pulse_input_ale_en,
    input  wire logic       i_programming_pulse_input_ale,
    // Pins and tallies
    output logic            o_ps_pin,
    output logic            o_ale_pin,
    output int              o_ps_cnt,
    output int              o_ale_cnt,
    output int              o_rd_cnt,
    output int              o_wr_cnt,
    output logic [7:0]      o_code_hi,
    output logic [7:0]      o_data_hi
);
    bit ps_q, ale_q, rd_q, wr_q, ale_last;
    // ==========================================================
    // Pin levels
    // ==========================================================
    // Released latch pin floats, so it shows a moving level
    always_comb begin
        o_ps_pin = !i_ps_oe_n ? i_ps_n : i_programming_pulse_input_ps;
        o_ale_pin = !i_ale_oe_n ? i_ale : i_programming_pulse_input_ale_en ? i_programming_pulse_input_ale : ~ale_last;
    end
    // ==========================================================
    // Memory side
    // ==========================================================
    always_ff @(posedge i_core_clk) begin
        ale_last <= o_ale_pin;
        ps_q <= i_ps_n;
        ale_q <= i_ale;
        rd_q <= i_rd_n;
        wr_q <= i_wr_n;
        if (ps_q && !i_ps_n) o_ps_cnt <= o_ps_cnt + 1;
        if (!ale_q && i_ale) o_ale_cnt <= o_ale_cnt + 1;
        if (ale_q && !i_ale) o_code_hi <= i_addr_hi;
        if (rd_q && !i_rd_n) o_rd_cnt <= o_rd_cnt + 1;
        if (wr_q && !i_wr_n) o_wr_cnt <= o_wr_cnt + 1;
        if ((rd_q && !i_rd_n) || (wr_q && !i_wr_n)) o_data_hi <= i_addr_hi;
    end
endmodule

// File: tb/tb_external_bus_strobe_and_mode_entry.sv
`timescale 1ns/100ps
module tb_external_bus_strobe_and_mode_entry;
    import ebsme_pkg::*;
    // ==========================================================
    // Signals
    // ==========================================================
    logic         clk = 1'h0, rst_b = 1'h0, tick = 1'h0, dbl = 1'h0, off = 1'h0;
    logic         rpin = 1'h0, ea = 1'h1, pps = 1'h1, pale_en = 1'h0, pale = 1'h0;
    logic [1:0]   lock = 2'h0;
    logic [15:0]  faddr = 16'h1234;
    ebsme_xdata_s xd = '0;
    logic         ps_pin, ale_pin, strb, strb_oe_n, ale, ale_oe_n, rd_n, wr_n;
    logic         hi_oe_n, core_rst, host, ext, mcs, ppi;
    logic [7:0]   hi, code_hi, data_hi;
    int           ps_cnt, ale_cnt, rd_cnt, wr_cnt, a0, p0, r0, w0, clks;
    int           bad_count = 0;
    int           n_tests = 0;

    always #5 clk = ~clk;
    // Crystal at half the core rate
    always @(posedge clk) tick <= ~tick;

    ebsme_top u_dut (
        .i_core_clk(clk), .i_rst_b(rst_b), .i_osc_tick(tick), .i_double_speed(dbl),
        .i_latch_strobe_off_bit(off), .i_lock_level(lock), .i_fetch_addr(faddr),
        .i_xdata(xd), .i_reset_pin(rpin), .i_external_access_select(ea),
        .i_ps_rd_pin(ps_pin), .i_ale_pin(ale_pin), .o_program_store_read_strobe(strb),
        .o_program_store_read_strobe_oe_n(strb_oe_n), .o_ale(ale), .o_ale_oe_n(ale_oe_n),
        .o_rd_n(rd_n), .o_wr_n(wr_n), .o_addr_hi(hi), .o_addr_hi_oe_n(hi_oe_n),
        .o_core_reset(core_rst), .o_host_mode(host), .o_external_exec(ext),
        .o_mc_start(mcs), .o_programming_pulse_input(ppi)
    );
    ebsme_mem_model u_mem (
        .i_core_clk(clk), .i_ps_n(strb), .i_ps_oe_n(strb_oe_n), .i_ale(ale),
        .i_ale_oe_n(ale_oe_n), .i_rd_n(rd_n), .i_wr_n(wr_n), .i_addr_hi(hi),
        .i_programming_pulse_input_ps(pps), .i_programming_pulse_input_ale_en(pale_en), .i_programming_pulse_input_ale(pale), .o_ps_pin(ps_pin),
        .o_ale_pin(ale_pin), .o_ps_cnt(ps_cnt), .o_ale_cnt(ale_cnt), .o_rd_cnt(rd_cnt),
        .o_wr_cnt(wr_cnt), .o_code_hi(code_hi), .o_data_hi(data_hi)
    );
    // ==========================================================
    // Helpers
    // ==========================================================
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %0h, expected %0h", $time, got, exp);
        end
    endtask

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Waits for n machine cycle starts; windows always open at the same phase
    task automatic mcw(input int n);
        int k;
        for (int i = 0; i < n; i++) begin
            k = 0;
            do begin
                @(posedge clk);
                k++;
                clks++;
            end while (mcs !== 1'h1 && k < 100);
            if (k >= 100) begin
                bad_count++;
                summarize();
            end
        end
    endtask

    task automatic snap();
        a0 = ale_cnt;
        p0 = ps_cnt;
        r0 = rd_cnt;
        w0 = wr_cnt;
        clks = 0;
    endtask
    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic t_rates(input logic x2);
        dbl <= x2;
        mcw(2);
        snap();
        mcw(4);
        check(clks, 8 * (x2 ? OSC_PER_MC_X2 : OSC_PER_MC_X1));
        check(ale_cnt - a0, 8);
        check(ps_cnt - p0, 0);
        check(ext, 1'h0);
    endtask

    task automatic t_ext();
        ea <= 1'h0;
        mcw(2);
        snap();
        mcw(4);
        check(ps_cnt - p0, 8);
        check(ext, 1'h1);
        check(code_hi, faddr[15:8]);
        check(hi_oe_n, 1'h0);
    endtask

    task automatic t_data(input logic wr);
        snap();
        xd <= '{1'h1, wr, 1'h1, 16'hA55A, 8'h3C};
        mcw(1);
        xd <= '0;
        mcw(2);
        check(ale_cnt - a0, 5);
        check(ps_cnt - p0, 5);
        check(rd_cnt - r0, {31'h0, !wr});
        check(wr_cnt - w0, {31'h0, wr});
        check(data_hi, 8'hA5);
    endtask

    task automatic t_off_lock();
        off <= 1'h1;
        mcw(1);
        snap();
        mcw(3);
        check(ale_cnt - a0, 0);
        off <= 1'h0;
        lock <= 2'h3;
        mcw(2);
        snap();
        mcw(3);
        check(ps_cnt - p0, 0);
        check(ext, 1'h0);
        lock <= 2'h0;
        ea <= 1'h1;
    endtask

    task automatic t_reset();
        rpin <= 1'h1;
        repeat (10) @(posedge clk);
        rpin <= 1'h0;
        mcw(2);
        check(core_rst, 1'h0);
        rpin <= 1'h1;
        mcw(4);
        check(core_rst, 1'h1);
        check(host, 1'h0);
        rpin <= 1'h0;
        mcw(2);
        check(core_rst, 1'h0);
    endtask

    task automatic t_host();
        rpin <= 1'h1;
        mcw(8);
        pps <= 1'h0;
        mcw(1);
        check(host, 1'h0);
        pps <= 1'h1;
        rpin <= 1'h0;
        mcw(2);
        rpin <= 1'h1;
        mcw(25);
        pps <= 1'h0;
        mcw(1);
        check(host, 1'h1);
        pale_en <= 1'h1;
        pale <= 1'h1;
        repeat (3) @(posedge clk);
        check(ppi, 1'h1);
        pale <= 1'h0;
        repeat (3) @(posedge clk);
        check(ppi, 1'h0);
        rpin <= 1'h0;
        mcw(2);
        check(host, 1'h0);
    endtask

    initial begin
        repeat (4) @(posedge clk);
        rst_b <= 1'h1;
        mcw(2);
        t_rates(1'h0);
        t_rates(1'h1);
        dbl <= 1'h0;
        t_ext();
        t_data(1'h0);
        t_data(1'h1);
        t_off_lock();
        t_reset();
        t_host();
        summarize();
    end
endmodule
